// File: logic/tadio_regs.vh
// Register map, field layout, reset values and timing of the alarm/DIO unit.
// Assumes an APB slave with an 8-bit byte address and 32-bit data.
`ifndef TADIO_REGS_VH
`define TADIO_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TADIO_DIN_OFS 8'h00
`define TADIO_DOUT_OFS 8'h04
`define TADIO_LINES_OFS 8'h08
`define TADIO_ASTATE_OFS 8'h0c
`define TADIO_ASEL_OFS 8'h10
`define TADIO_ACFG_OFS 8'h14
`define TADIO_AFT_OFS 8'h18
`define TADIO_AST_OFS 8'h1c
`define TADIO_STAT_OFS 8'h20
`define TADIO_ARAW_OFS 8'h24

// ----------------------------------------------------------------------
// Alarm configuration fields
// ----------------------------------------------------------------------
`define TADIO_CFG_W 7
`define TADIO_CFG_IN 1:0
`define TADIO_CFG_ERR 3:2
`define TADIO_CFG_OUT 5:4
`define TADIO_CFG_LATCH 6
`define TADIO_IN_RISE 2'h0
`define TADIO_IN_FALL 2'h1
`define TADIO_IN_WIN 2'h2
`define TADIO_ERR_TEMP 2'h0
`define TADIO_ERR_ANY 2'h1
`define TADIO_ERR_ONLY 2'h2
`define TADIO_OUT_OFF 2'h0
`define TADIO_OUT_HI 2'h1
`define TADIO_OUT_LO 2'h2

// ----------------------------------------------------------------------
// Stored word layout: {cfg, second_threshold, first_threshold}
// ----------------------------------------------------------------------
`define TADIO_TW 16
`define TADIO_NVW 39
`define TADIO_NV_FT 15:0
`define TADIO_NV_ST 31:16
`define TADIO_NV_CFG 38:32

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define TADIO_DOUT_RST 32'hffffffff
`define TADIO_CFG_RST 7'h00
`define TADIO_THR_RST 16'h0000
`define TADIO_ALARM_LAT_MS 1000
`define TADIO_NV_RD_LAT 1

`endif

// File: logic/tadio_unit.v
// Temperature alarm engine with 8-bit input port and 32 open-drain outputs.
// Assumes conversions arrive on pclk and a store with one-cycle read latency.
`timescale 1ns/100ps
`include "tadio_regs.vh"
`default_nettype none

module tadio_unit #(
  parameter NIN = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [NIN-1:0] din_i,
  input wire [31:0] dio_i,
  output wire [31:0] dio_o,
  output wire [31:0] dio_oe,
  input wire temp_valid,
  input wire [4:0] temp_chan,
  input wire [`TADIO_TW-1:0] temp_value,
  input wire open_tc,
  input wire cm_err,
  output wire nv_rd,
  output wire nv_wr,
  output wire [4:0] nv_idx,
  output wire [`TADIO_NVW-1:0] nv_wdata,
  input wire [`TADIO_NVW-1:0] nv_rdata
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam SW = NIN + 32; // Synchronised pin count
  localparam S_REQ = 2'h0; // Issue store read
  localparam S_WAIT = 2'h1; // Store latency
  localparam S_CAP = 2'h2; // Capture stored word
  localparam S_RUN = 2'h3; // Normal operation

  reg [1:0] state_reg; // Load sequencer
  reg [4:0] ld_idx_reg; // Alarm being reloaded
  reg [SW-1:0] s1_reg; // Pin stage one
  reg [SW-1:0] s2_reg; // Pin stage two
  reg [SW-1:0] s3_reg; // Pin stage three
  reg [SW-1:0] pin_reg; // Accepted pin levels
  reg [31:0] dout_reg; // Software output value
  reg [4:0] sel_reg; // Alarm selected for access
  reg [`TADIO_CFG_W-1:0] cfg_mem [0:31]; // Per-alarm modes
  reg [`TADIO_TW-1:0] ft_mem [0:31]; // Per-alarm first_threshold
  reg [`TADIO_TW-1:0] st_mem [0:31]; // Per-alarm second_threshold
  reg [31:0] tcond_reg; // Temperature condition
  reg [31:0] err_reg; // Sensor error seen
  reg [31:0] act_reg; // Alarm output state
  reg [31:0] oe_reg; // Drain drive enables
  reg [31:0] prdata_reg; // Read data
  reg pready_reg; // Access complete
  reg pslverr_reg; // Unmapped access
  reg nv_rd_reg; // Store read strobe
  reg nv_wr_reg; // Store write strobe
  reg [4:0] nv_idx_reg; // Store index
  reg [`TADIO_NVW-1:0] nv_wdata_reg; // Store write word
  reg wpend_reg; // Settings changed last cycle
  reg [4:0] widx_reg; // Alarm whose settings changed
  reg [31:0] rdata_next; // Read mux result
  reg hit_next; // Address is mapped
  reg tnew; // New temperature condition
  integer k; // Reset loop index

  wire run = (state_reg == S_RUN);
  wire acc = psel & penable;
  wire wr_en = acc & pwrite & pready_reg; // Write takes effect here
  wire [31:0] bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire wr_dout = wr_en & (paddr == `TADIO_DOUT_OFS);
  wire wr_sel = wr_en & (paddr == `TADIO_ASEL_OFS);
  wire wr_cfg = wr_en & (paddr == `TADIO_ACFG_OFS);
  wire wr_ft = wr_en & (paddr == `TADIO_AFT_OFS);
  wire wr_st = wr_en & (paddr == `TADIO_AST_OFS);
  wire [31:0] clr = (wr_en & (paddr == `TADIO_ASTATE_OFS)) ? pwdata : 32'h00000000;
  wire [31:0] raw; // Combined alarm condition
  wire [31:0] level; // Wanted line level
  wire signed [`TADIO_TW-1:0] tv = temp_value;
  wire signed [`TADIO_TW-1:0] tft = ft_mem[temp_chan];
  wire signed [`TADIO_TW-1:0] tst = st_mem[temp_chan];
  wire [1:0] tmode = cfg_mem[temp_chan][`TADIO_CFG_IN];
  wire [31:0] din_ext = {{(32-NIN){1'b0}}, pin_reg[NIN-1:0]};

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Three stages; a bit is accepted once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= {SW{1'b1}};
      s2_reg <= {SW{1'b1}};
      s3_reg <= {SW{1'b1}};
      pin_reg <= {SW{1'b1}};
    end else begin
      s1_reg <= {dio_i, din_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (pin_reg & (s2_reg ^ s3_reg));
    end
  end

  // ----------------------------------------------------------------------
  // Power-on reload sequencer
  // ----------------------------------------------------------------------
  // Walks all alarms, reading each stored word before running
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_REQ;
      ld_idx_reg <= 5'h00;
    end else begin
      case (state_reg)
        S_REQ: begin
          state_reg <= S_WAIT;
        end
        S_WAIT: begin
          state_reg <= S_CAP;
        end
        S_CAP: begin
          // Last alarm loaded, start running
          if (ld_idx_reg == 5'h1f) begin
            state_reg <= S_RUN;
          end else begin
            state_reg <= S_REQ;
          end
          ld_idx_reg <= ld_idx_reg + 5'h01;
        end
        S_RUN: begin
          state_reg <= S_RUN;
        end
        default: begin
          state_reg <= S_REQ;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Alarm settings storage
  // ----------------------------------------------------------------------
  // Loaded from the store, then changed by software at the selected alarm
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (k = 0; k < 32; k = k + 1) begin
        cfg_mem[k] <= `TADIO_CFG_RST;
        ft_mem[k] <= `TADIO_THR_RST;
        st_mem[k] <= `TADIO_THR_RST;
      end
    end else if (state_reg == S_CAP) begin
      // Stored word of the alarm being reloaded
      cfg_mem[ld_idx_reg] <= nv_rdata[`TADIO_NV_CFG];
      ft_mem[ld_idx_reg] <= nv_rdata[`TADIO_NV_FT];
      st_mem[ld_idx_reg] <= nv_rdata[`TADIO_NV_ST];
    end else begin
      // Immediate effect of a software change
      if (wr_cfg) begin
        cfg_mem[sel_reg] <= pwdata[`TADIO_CFG_W-1:0];
      end
      if (wr_ft) begin
        ft_mem[sel_reg] <= pwdata[`TADIO_TW-1:0];
      end
      if (wr_st) begin
        st_mem[sel_reg] <= pwdata[`TADIO_TW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  // Output port value and alarm selector
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_reg <= `TADIO_DOUT_RST;
      sel_reg <= 5'h00;
    end else begin
      if (wr_dout) begin
        dout_reg <= (pwdata & bmask) | (dout_reg & ~bmask);
      end
      if (wr_sel) begin
        sel_reg <= pwdata[4:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Store interface
  // ----------------------------------------------------------------------
  // Reads during reload; a write follows each settings change
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_rd_reg <= 1'b0;
      nv_wr_reg <= 1'b0;
      nv_idx_reg <= 5'h00;
      nv_wdata_reg <= {`TADIO_NVW{1'b0}};
      wpend_reg <= 1'b0;
      widx_reg <= 5'h00;
    end else begin
      nv_rd_reg <= (state_reg == S_REQ);
      wpend_reg <= wr_cfg | wr_ft | wr_st;
      widx_reg <= sel_reg;
      nv_wr_reg <= wpend_reg;
      if (state_reg == S_REQ) begin
        nv_idx_reg <= ld_idx_reg;
      end else if (wpend_reg) begin
        // Written one cycle late so the word holds the new field
        nv_idx_reg <= widx_reg;
        nv_wdata_reg <= {cfg_mem[widx_reg], st_mem[widx_reg], ft_mem[widx_reg]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Shared threshold comparator
  // ----------------------------------------------------------------------
  // Evaluates the converting channel against its own thresholds
  always @* begin
    tnew = tcond_reg[temp_chan];
    case (tmode)
      `TADIO_IN_RISE: begin
        // Set at or above first, reset below second
        if (tv >= tft) begin
          tnew = 1'b1;
        end else if (tv < tst) begin
          tnew = 1'b0;
        end
      end
      `TADIO_IN_FALL: begin
        // Set at or below first, reset above second
        if (tv <= tft) begin
          tnew = 1'b1;
        end else if (tv > tst) begin
          tnew = 1'b0;
        end
      end
      `TADIO_IN_WIN: begin
        // Outside the window, clear inside inclusive range
        tnew = (tv < tft) | (tv > tst);
      end
      default: begin
        tnew = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Per-alarm state and line drive
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : alarm
      wire [`TADIO_CFG_W-1:0] cfg = cfg_mem[g];
      // Channel g converts; needs no host activity
      wire hit = run & temp_valid & (temp_chan == g);

      // Error mode selects temperature, sensor faults or both combined
      assign raw[g] = (cfg[`TADIO_CFG_ERR] == `TADIO_ERR_TEMP) ? tcond_reg[g] :
                      (cfg[`TADIO_CFG_ERR] == `TADIO_ERR_ANY) ? (tcond_reg[g] | err_reg[g]) :
                      (cfg[`TADIO_CFG_ERR] == `TADIO_ERR_ONLY) ? err_reg[g] :
                      1'b0;

      // Alarm mode picks level, otherwise software value
      assign level[g] = (cfg[`TADIO_CFG_OUT] == `TADIO_OUT_HI) ? act_reg[g] :
                        (cfg[`TADIO_CFG_OUT] == `TADIO_OUT_LO) ? ~act_reg[g] :
                        dout_reg[g];

      // Condition capture, alarm state and drain drive
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tcond_reg[g] <= 1'b0;
          err_reg[g] <= 1'b0;
          act_reg[g] <= 1'b0;
          oe_reg[g] <= 1'b0;
        end else begin
          if (hit) begin
            tcond_reg[g] <= tnew;
            err_reg[g] <= open_tc | cm_err;
          end
          if (cfg[`TADIO_CFG_LATCH]) begin
            // New condition wins over a clear in the same cycle
            act_reg[g] <= raw[g] | (act_reg[g] & ~clr[g]);
          end else begin
            act_reg[g] <= raw[g];
          end
          // Low level turns the transistor on
          oe_reg[g] <= ~level[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // APB read mux
  // ----------------------------------------------------------------------
  // Unmapped addresses read zero and flag an error
  always @* begin
    rdata_next = 32'h00000000;
    hit_next = 1'b1;
    case (paddr)
      `TADIO_DIN_OFS: begin
        rdata_next = din_ext;
      end
      `TADIO_DOUT_OFS: begin
        rdata_next = dout_reg;
      end
      `TADIO_LINES_OFS: begin
        rdata_next = pin_reg[SW-1:NIN];
      end
      `TADIO_ASTATE_OFS: begin
        rdata_next = act_reg;
      end
      `TADIO_ASEL_OFS: begin
        rdata_next = {27'h0000000, sel_reg};
      end
      `TADIO_ACFG_OFS: begin
        rdata_next = {25'h0000000, cfg_mem[sel_reg]};
      end
      `TADIO_AFT_OFS: begin
        rdata_next = {16'h0000, ft_mem[sel_reg]};
      end
      `TADIO_AST_OFS: begin
        rdata_next = {16'h0000, st_mem[sel_reg]};
      end
      `TADIO_STAT_OFS: begin
        rdata_next = {31'h00000000, run};
      end
      `TADIO_ARAW_OFS: begin
        rdata_next = raw;
      end
      default: begin
        hit_next = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------------
  // One wait state; held off until reload is finished
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= acc & ~pready_reg & run;
      if (acc & ~pready_reg & run) begin
        pslverr_reg <= ~hit_next;
        prdata_reg <= pwrite ? 32'h00000000 : rdata_next;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign dio_o = 32'h00000000;
  assign dio_oe = oe_reg;
  assign nv_rd = nv_rd_reg;
  assign nv_wr = nv_wr_reg;
  assign nv_idx = nv_idx_reg;
  assign nv_wdata = nv_wdata_reg;

endmodule // tadio_unit

`default_nettype wire

// File: sim/tadio_nv_model.sv
// Behavioural settings store standing behind the alarm unit.
// Assumes one-cycle read latency; scrambles data outside the window.
`timescale 1ns/100ps
`default_nettype none
module tadio_nv_model (
  input wire logic clk,
  input wire logic rd,
  input wire logic wr,
  input wire logic [4:0] idx,
  input wire logic [38:0] wdata,
  output logic [38:0] rdata
);
  logic [38:0] mem [0:31]; // Stored alarm words
  logic hold; // Read window open
  // ----------------------------------------
  // Preset contents
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 32; i++) mem[i] = 39'h0;
    mem[7] = {7'h20, 16'h0032, 16'h0064}; // Rise, low output, 100/50
    rdata = 39'h0;
    hold = 1'b0;
  end
  // Answer next cycle, then stop showing the word
  always @(posedge clk) begin
    hold <= rd;
    if (rd) rdata <= mem[idx];
    else if (hold) rdata <= ~rdata;
    if (wr) mem[idx] <= wdata;
  end
endmodule // tadio_nv_model
`default_nettype wire

// File: sim/tadio_unit_assertions.sv
// Port checks on the alarm unit, bound to every instance.
// Assumes the register header is on the include path.
`timescale 1ns/100ps
`include "tadio_regs.vh"
`default_nettype none
module tadio_unit_assertions #(
  parameter NIN = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NIN-1:0] din_i,
  input wire logic [31:0] dio_i,
  input wire logic [31:0] dio_o,
  input wire logic [31:0] dio_oe,
  input wire logic temp_valid,
  input wire logic [4:0] temp_chan,
  input wire logic [15:0] temp_value,
  input wire logic open_tc,
  input wire logic cm_err,
  input wire logic nv_rd,
  input wire logic nv_wr,
  input wire logic [4:0] nv_idx,
  input wire logic [38:0] nv_wdata,
  input wire logic [38:0] nv_rdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire done = psel && penable && pready && pwrite && !pslverr; // Write lands
  logic [31:0] last_wd; // Data of last write
  // Keep write data for the store checks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) last_wd <= 32'h0;
    else if (done) last_wd <= pwdata;
  end
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer carries data");
  answer_bound_a: assert property (psel && penable && !pready |-> ##[0:200] pready)
    else $error("access not answered");
  drain_only_a: assert property (dio_o == 32'h0)
    else $error("open drain data not zero");
  reload_start_a: assert property ($rose(presetn) |-> ##[0:8] nv_rd)
    else $error("no reload after reset");
  rd_pulse_a: assert property (nv_rd |=> !nv_rd)
    else $error("store read too long");
  cfg_store_a: assert property (done && paddr == `TADIO_ACFG_OFS |->
    ##[1:3] (nv_wr && nv_wdata[`TADIO_NV_CFG] == last_wd[6:0]))
    else $error("mode write not stored");
  ft_store_a: assert property (done && paddr == `TADIO_AFT_OFS |->
    ##[1:3] (nv_wr && nv_wdata[`TADIO_NV_FT] == last_wd[15:0]))
    else $error("threshold write not stored");
  slverr_c: cover property (pslverr);
  store_c: cover property (nv_wr);
  line_c: cover property ($changed(dio_oe));
endmodule // tadio_unit_assertions
bind tadio_unit tadio_unit_assertions #(.NIN(NIN)) u_tadio_unit_assertions (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .din_i,
  .dio_i, .dio_o, .dio_oe, .temp_valid, .temp_chan, .temp_value, .open_tc, .cm_err, .nv_rd,
  .nv_wr, .nv_idx, .nv_wdata, .nv_rdata);
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the alarm unit with a settings store model.
// Assumes the unit, its header and the store model are compiled first.
`timescale 1ns/100ps
`include "tadio_regs.vh"
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, temp_valid, open_tc, cm_err;
  logic [7:0] paddr, din_i;
  logic [31:0] pwdata, dio_i, dout, rd;
  logic [4:0] temp_chan, g;
  logic [15:0] temp_value;
  wire [31:0] prdata, dio_o, dio_oe;
  wire pready, pslverr, nv_rd, nv_wr;
  wire [4:0] nv_idx;
  wire [38:0] nv_wdata, nv_rdata;
  int errors, cmp_count;
  logic er, c_lat, hy, cond, act; // Bench view of the alarm
  logic [1:0] c_in, c_err, c_out;
  logic signed [15:0] c_ft, c_st;
  int seq[$]; // Temperatures for one directed run
  tadio_unit u_tadio_unit (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .din_i, .dio_i, .dio_o, .dio_oe, .temp_valid,
    .temp_chan, .temp_value, .open_tc, .cm_err, .nv_rd, .nv_wr, .nv_idx, .nv_wdata, .nv_rdata);
  tadio_nv_model u_tadio_nv_model (.clk(pclk), .rd(nv_rd), .wr(nv_wr), .idx(nv_idx),
    .wdata(nv_wdata), .rdata(nv_rdata));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ----------------------------------------
  // Compare, verdict and bus tasks
  // ----------------------------------------
  task automatic check(input logic [38:0] seen, input logic [38:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 400);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // A missing answer counts as a mismatch and ends the run
    if (pready !== 1'b1) begin
      errors++;
      give_verdict();
    end
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check(dio_oe, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, `TADIO_STAT_OFS, 32'h0);
    check(rd[0], 1'b1);
  endtask
  task automatic conv(input logic [4:0] ch, input logic [15:0] t, input logic [1:0] e);
    @(posedge pclk);
    temp_valid <= 1'b1;
    temp_chan <= ch;
    temp_value <= t;
    open_tc <= e[0];
    cm_err <= e[1];
    @(posedge pclk);
    temp_valid <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  // ----------------------------------------
  // Expected alarm behaviour
  // ----------------------------------------
  function automatic logic next_tc(input logic signed [15:0] t);
    case (c_in)
      `TADIO_IN_RISE: return (t >= c_ft) ? 1'b1 : (t < c_st) ? 1'b0 : hy;
      `TADIO_IN_FALL: return (t <= c_ft) ? 1'b1 : (t > c_st) ? 1'b0 : hy;
      `TADIO_IN_WIN: return (t < c_ft) || (t > c_st);
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic err_cond(input logic tc, input logic e);
    case (c_err)
      `TADIO_ERR_TEMP: return tc;
      `TADIO_ERR_ANY: return tc | e;
      `TADIO_ERR_ONLY: return e;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic line_oe(input logic a);
    case (c_out)
      `TADIO_OUT_HI: return !a;
      `TADIO_OUT_LO: return a;
      default: return !dout[g];
    endcase
  endfunction
  task automatic setcfg(input logic [6:0] cf, input logic signed [15:0] ft, st);
    {c_lat, c_out, c_err, c_in} = cf;
    c_ft = ft;
    c_st = st;
    apb(1'b1, `TADIO_ASEL_OFS, {27'h0, g});
    apb(1'b1, `TADIO_ACFG_OFS, {25'h0, cf});
    apb(1'b1, `TADIO_AFT_OFS, {16'h0, ft});
    apb(1'b1, `TADIO_AST_OFS, {16'h0, st});
    repeat (3) @(posedge pclk);
    check(u_tadio_nv_model.mem[g], {cf, st, ft});
  endtask
  task automatic step(input logic signed [15:0] t, input logic [1:0] e);
    hy = next_tc(t);
    cond = err_cond(hy, |e);
    act = c_lat ? (act | cond) : cond;
    conv(g, t, e);
    check(dio_oe[g], line_oe(act));
    apb(1'b0, `TADIO_ASTATE_OFS, 32'h0);
    check(rd[g], act);
    apb(1'b0, `TADIO_ARAW_OFS, 32'h0);
    check(rd[g], cond);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, temp_valid, open_tc, cm_err} = 7'h0;
    {paddr, din_i, pwdata, dio_i, temp_chan, temp_value} = 101'h0;
    {errors, cmp_count, act, hy} = 66'h0;
    dout = `TADIO_DOUT_RST;
    void'($urandom(25));
    g = 5'd8 + 5'($urandom % 24);
    do_reset();
    apb(1'b0, `TADIO_DOUT_OFS, 32'h0);
    check(rd, `TADIO_DOUT_RST);
    apb(1'b0, 8'h28, 32'h0);
    check({er, rd}, {1'b1, 32'h0});
    din_i <= 8'($urandom);
    dio_i <= $urandom;
    repeat (6) @(posedge pclk);
    apb(1'b0, `TADIO_DIN_OFS, 32'h0);
    check(rd, {24'h0, din_i});
    apb(1'b0, `TADIO_LINES_OFS, 32'h0);
    check(rd, dio_i);
    conv(5'd7, 16'h0078, 2'h0);
    check(dio_oe[7], 1'b1);
    dout = $urandom;
    apb(1'b1, `TADIO_DOUT_OFS, dout);
    repeat (3) @(posedge pclk);
    check(dio_oe & 32'hffffff7f, ~dout & 32'hffffff7f);
    setcfg(7'h10, 100, 50);
    step(20, 2'h1);
    seq = '{120, 70, 40, 70, 100};
    foreach (seq[i]) step(seq[i], 2'h0);
    setcfg(7'h21, 10, 60);
    seq = '{5, 30, 70, 30, 10};
    foreach (seq[i]) step(seq[i], 2'h0);
    setcfg(7'h16, -10, 20);
    seq = '{-10, 20, -11, 21};
    foreach (seq[i]) step(seq[i], 2'h0);
    repeat (10) step(16'(int'($urandom % 91) - 40), 2'($urandom));
    setcfg(7'h28, 100, 50);
    step(200, 2'h0);
    step(0, 2'h2);
    step(0, 2'h1);
    setcfg(7'h50, 100, 50);
    step(120, 2'h0);
    step(40, 2'h0);
    apb(1'b1, `TADIO_ASTATE_OFS, 32'h1 << g);
    act = cond;
    step(40, 2'h0);
    do_reset();
    apb(1'b1, `TADIO_ASEL_OFS, {27'h0, g});
    apb(1'b0, `TADIO_ACFG_OFS, 32'h0);
    check(rd, 32'h50);
    apb(1'b0, `TADIO_AFT_OFS, 32'h0);
    check(rd, 32'h64);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
